// ### hw/lcfs_pkg.sv
// Constants shared by the link check frame scheduler
package lcfs_pkg;
  // Register byte offsets
  localparam logic [3:0] CTRL_OFS  = 4'h0;
  localparam logic [3:0] STAT_OFS  = 4'h4;
  localparam logic [3:0] FRAME_OFS = 4'h8;
  // Control register fields
  localparam int CTRL_TP_BIT  = 0;   // Tele-powering commanded on
  localparam int CTRL_SS_BIT  = 1;   // Strength reporting enabled
  localparam int CTRL_OPT_LSB = 4;   // Optional link test bit count, 4 bits
  localparam int CTRL_ANT_LSB = 8;   // Antenna identifier, 2 bits
  localparam int CTRL_LNK_LSB = 10;  // Link identifier, 2 bits
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_0FF3;
  // Link test shape
  localparam logic [4:0] LC_MAND = 5'h04;  // Mandatory bits
  localparam logic [4:0] LC_OPT_MAX = 5'h0F;  // Most optional bits
  localparam logic [3:0] LC_PATTERN = 4'hA; // Mandatory detection bits, msb first
  // Timing in physical units
  localparam int CLK_MHZ     = 10;
  localparam int IDLE_MS     = 200;   // Below the 250 ms window
  localparam int SUPP_MS     = 750;   // Between 0.5 s and 1 s
  localparam int LC_BIT_US   = 10;    // Link test bit slot
  localparam int IDLE_CYC    = IDLE_MS * 1000 * CLK_MHZ;
  localparam int SUPP_CYC    = SUPP_MS * 1000 * CLK_MHZ;
  localparam logic [9:0] LC_BIT_CYC = 10'(LC_BIT_US * CLK_MHZ - 1);
  // AXI responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_DEC = 2'h3;
  // Frame: payload 17 bits then CRC-8
  localparam int PAY_W   = 17;
  localparam int FRAME_W = 25;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] CRC_INIT = 8'h00;
  // Link test sequencer states
  typedef enum logic [1:0] {
    LC_IDLE = 2'b01,
    LC_SEND = 2'b10
  } lcfs_lc_t;
endpackage : lcfs_pkg

// ### hw/lcfs_crc.sv
// CRC-8 generator over one frame payload
`timescale 1ns/10ps
`default_nettype none
module lcfs_crc (
  // Payload in
  input  wire logic [lcfs_pkg::PAY_W-1:0] pay_i,
  // Check value out
  output logic      [7:0]                 crc_o
);
  // Bitwise CRC, payload msb first
  function automatic logic [7:0] lcfs_crc8(input logic [lcfs_pkg::PAY_W-1:0] d);
    logic [7:0] c;
    c = lcfs_pkg::CRC_INIT;
    for (int i = lcfs_pkg::PAY_W - 1; i >= 0; i--) begin
      if (c[7] ^ d[i]) begin
        c = {c[6:0], 1'b0} ^ lcfs_pkg::CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction : lcfs_crc8

  // Pure combinational check value
  always_comb begin
    crc_o = lcfs_crc8(pay_i);
  end
endmodule : lcfs_crc
`default_nettype wire

// ### hw/lcfs_top.sv
// Link check frame scheduler with AXI4-Lite control
//
// Chosen here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Idle link: link test within every 250 ms
// - Each link test carries four mandatory bits
// - At most fifteen optional bits appended
// - Link test flag matches link test frames
// - ASK reception: link test after 0.5..1 s
// - FSK reception: link test after 0.5..1 s
// - Detection bit follows received air-gap bit
// - Decoding bit equals detection bit
// - ASK frames: three status flags zero
// - Strength nibble zero unless reporting enabled
// - Bit counter steps modulo 8 per bit
// - Every frame carries its CRC
// - Antenna and link identifiers from configuration
// - FSK: detection and decoding bits zero
// - FSK: reception flag one, others zero
// - FSK: tele-powering flag one
// - Tele-powering off sets unavailability flag
// - Permanent failure stops all output activity
module lcfs_top #(
  parameter logic [22:0] IDLE_CYC = 23'(lcfs_pkg::IDLE_CYC),
  parameter logic [22:0] SUPP_CYC = 23'(lcfs_pkg::SUPP_CYC)
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  // AXI4-Lite write channels
  input  wire logic [3:0]  s_awaddr_i,
  input  wire logic        s_awvalid_i,
  output logic             s_awready_o,
  input  wire logic [31:0] s_wdata_i,
  input  wire logic [3:0]  s_wstrb_i,
  input  wire logic        s_wvalid_i,
  output logic             s_wready_o,
  output logic [1:0]       s_bresp_o,
  output logic             s_bvalid_o,
  input  wire logic        s_bready_i,
  // AXI4-Lite read channels
  input  wire logic [3:0]  s_araddr_i,
  input  wire logic        s_arvalid_i,
  output logic             s_arready_o,
  output logic [31:0]      s_rdata_o,
  output logic [1:0]       s_rresp_o,
  output logic             s_rvalid_o,
  input  wire logic        s_rready_i,
  // Air-gap receiver side
  input  wire logic        bit_strobe_i,   // One pulse per air-gap bit slot
  input  wire logic        ask_bit_i,      // Received ASK bit value
  input  wire logic        ask_rx_i,       // ASK data being received
  input  wire logic        fsk_rx_i,       // FSK telegram being received
  input  wire logic [3:0]  strength_i,     // Uplink signal level
  input  wire logic        fail_i,         // Permanent internal failure
  // Output link
  output logic             frame_valid_o,  // One pulse per frame
  output logic [24:0]      frame_data_o,   // Payload msb first, CRC last
  output logic             line_active_o   // Line coding running
);
  // Control and status registers
  logic [31:0] ctrl_q, ctrl_d;           // Control word
  logic        fail_q, fail_d;           // Latched failure
  // Bus handshake state
  logic        bvalid_q, bvalid_d;
  logic [1:0]  bresp_q, bresp_d;
  logic        rvalid_q, rvalid_d;
  logic [1:0]  rresp_q, rresp_d;
  logic [31:0] rdata_q, rdata_d;
  // Scheduler state
  lcfs_pkg::lcfs_lc_t lc_q, lc_d;        // Link test sequencer
  logic [22:0] gap_q, gap_d;             // Cycles since last link test
  logic [9:0]  tick_q, tick_d;           // Link test bit slot timer
  logic [4:0]  sent_q, sent_d;           // Link test bits sent
  logic [4:0]  len_q, len_d;             // Length of running link test
  logic [2:0]  bcnt_q, bcnt_d;           // Frame bit counter
  // Frame output registers
  logic        fv_q, fv_d;
  logic [24:0] fd_q, fd_d;
  logic        act_q, act_d;
  // Combinational helpers
  logic        wr_go, rd_go, rx_any, lc_tick, lc_due, emit;
  logic        det, is_lc;
  logic [16:0] pay;
  logic [7:0]  crc;
  logic [3:0]  opt;

  // Word offset decode shared by both bus paths
  function automatic logic [1:0] lcfs_dec(input logic [3:0] a);
    if (a == lcfs_pkg::CTRL_OFS) begin
      return 2'h1;
    end else if (a == lcfs_pkg::STAT_OFS) begin
      return 2'h2;
    end else if (a == lcfs_pkg::FRAME_OFS) begin
      return 2'h3;
    end else begin
      return 2'h0;
    end
  endfunction : lcfs_dec

  // Address and data are taken together, one write in flight
  assign s_awready_o = s_awvalid_i & s_wvalid_i & ~bvalid_q;
  assign s_wready_o  = s_awready_o;
  assign s_arready_o = ~rvalid_q;
  assign wr_go = s_awready_o;
  assign rd_go = s_arvalid_i & ~rvalid_q;
  assign s_bvalid_o = bvalid_q;
  assign s_bresp_o  = bresp_q;
  assign s_rvalid_o = rvalid_q;
  assign s_rresp_o  = rresp_q;
  assign s_rdata_o  = rdata_q;

  // Bus slave next state
  always_comb begin
    ctrl_d   = ctrl_q;
    bvalid_d = bvalid_q & ~s_bready_i;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q & ~s_rready_i;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    // Write with byte lanes, only control is writable
    if (wr_go) begin
      bvalid_d = 1'b1;
      bresp_d  = lcfs_pkg::RESP_OK;
      if (lcfs_dec(s_awaddr_i) == 2'h1) begin
        for (int b = 0; b < 4; b++) begin
          if (s_wstrb_i[b]) begin
            ctrl_d[b*8 +: 8] = s_wdata_i[b*8 +: 8] & lcfs_pkg::CTRL_WMASK[b*8 +: 8];
          end
        end
      end else if (lcfs_dec(s_awaddr_i) == 2'h0) begin
        bresp_d = lcfs_pkg::RESP_DEC;
      end
    end
    // Read, unmapped answers zero with decode error
    if (rd_go) begin
      rvalid_d = 1'b1;
      rresp_d  = lcfs_pkg::RESP_OK;
      case (lcfs_dec(s_araddr_i))
        2'h1: rdata_d = ctrl_q;
        2'h2: rdata_d = {16'h0000, 4'h0, sent_q, bcnt_q, 1'b0, act_q,
                         (lc_q == lcfs_pkg::LC_SEND), fail_q};
        2'h3: rdata_d = {7'h00, fd_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = lcfs_pkg::RESP_DEC;
        end
      endcase
    end
  end

  // Bus slave registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_q   <= lcfs_pkg::CTRL_RST;
      bvalid_q <= 1'b0;
      bresp_q  <= lcfs_pkg::RESP_OK;
      rvalid_q <= 1'b0;
      rresp_q  <= lcfs_pkg::RESP_OK;
      rdata_q  <= 32'h0000_0000;
    end else begin
      ctrl_q   <= ctrl_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  // Scheduler decisions
  assign rx_any  = ask_rx_i | fsk_rx_i;
  assign lc_tick = (tick_q == 10'h000);
  assign opt     = ctrl_q[lcfs_pkg::CTRL_OPT_LSB +: 4];
  // Due after the idle limit, or the suppression limit while receiving
  assign lc_due  = rx_any ? (gap_q >= SUPP_CYC) : (gap_q >= IDLE_CYC);
  assign is_lc   = (lc_q == lcfs_pkg::LC_SEND);
  // Link test bits leave on their own slot, normal frames on each air-gap bit
  assign emit    = ~fail_q & (is_lc ? lc_tick : bit_strobe_i);
  // Mandatory pattern first, optional bits send zero
  assign det = is_lc ? ((sent_q < lcfs_pkg::LC_MAND) ?
                        lcfs_pkg::LC_PATTERN[2'(3 - sent_q)] : 1'b0)
                     : (~fsk_rx_i & ask_bit_i);
  // Payload: det, dec, unavail, balise rx, link test, tele-power, ss, ant, link, counter
  assign pay = {det, det,
                ~ctrl_q[lcfs_pkg::CTRL_TP_BIT],
                fsk_rx_i & ~is_lc,
                is_lc,
                ctrl_q[lcfs_pkg::CTRL_TP_BIT] | fsk_rx_i,
                ctrl_q[lcfs_pkg::CTRL_SS_BIT] ? strength_i : 4'h0,
                ctrl_q[lcfs_pkg::CTRL_ANT_LSB +: 2],
                ctrl_q[lcfs_pkg::CTRL_LNK_LSB +: 2],
                bcnt_q};

  // CRC over the payload
  lcfs_crc u_crc (
    .pay_i (pay),
    .crc_o (crc)
  );

  // Scheduler next state
  always_comb begin
    lc_d   = lc_q;
    gap_d  = (gap_q == SUPP_CYC) ? gap_q : 23'(gap_q + 23'h00_0001);
    tick_d = lc_tick ? lcfs_pkg::LC_BIT_CYC : 10'(tick_q - 10'h001);
    sent_d = sent_q;
    len_d  = len_q;
    // Counter follows every air-gap bit, also under a link test
    bcnt_d = bit_strobe_i ? 3'(bcnt_q + 3'h1) : bcnt_q;
    fv_d   = emit;
    fd_d   = emit ? {pay, crc} : fd_q;
    act_d  = ~fail_q;
    fail_d = fail_q | fail_i;
    case (lc_q)
      lcfs_pkg::LC_IDLE: begin
        // Start only in a cycle that carries no frame
        if (lc_due && !bit_strobe_i && !fail_q) begin
          lc_d   = lcfs_pkg::LC_SEND;
          gap_d  = 23'h00_0000;
          sent_d = 5'h00;
          tick_d = lcfs_pkg::LC_BIT_CYC;
          len_d  = lcfs_pkg::LC_MAND +
                   ((5'(opt) > lcfs_pkg::LC_OPT_MAX) ? lcfs_pkg::LC_OPT_MAX : 5'(opt));
        end
      end
      lcfs_pkg::LC_SEND: begin
        gap_d = 23'h00_0000;
        if (emit) begin
          sent_d = 5'(sent_q + 5'h01);
          // Normal frames resume right after the last bit
          if (5'(sent_q + 5'h01) == len_q) begin
            lc_d = lcfs_pkg::LC_IDLE;
          end
        end
        if (fail_q) begin
          lc_d = lcfs_pkg::LC_IDLE;
        end
      end
      default: lc_d = lcfs_pkg::LC_IDLE;
    endcase
  end

  // Scheduler registers
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lc_q   <= lcfs_pkg::LC_IDLE;
      gap_q  <= 23'h00_0000;
      tick_q <= lcfs_pkg::LC_BIT_CYC;
      sent_q <= 5'h00;
      len_q  <= lcfs_pkg::LC_MAND;
      bcnt_q <= 3'h0;
      fv_q   <= 1'b0;
      fd_q   <= 25'h000_0000;
      act_q  <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      lc_q   <= lc_d;
      gap_q  <= gap_d;
      tick_q <= tick_d;
      sent_q <= sent_d;
      len_q  <= len_d;
      bcnt_q <= bcnt_d;
      fv_q   <= fv_d;
      fd_q   <= fd_d;
      act_q  <= act_d;
      fail_q <= fail_d;
    end
  end

  // Link outputs
  assign frame_valid_o = fv_q;
  assign frame_data_o  = fd_q;
  assign line_active_o = act_q;

  // Checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_lc_start;
    (lc_q == lcfs_pkg::LC_IDLE) ##1 (lc_q == lcfs_pkg::LC_SEND);
  endsequence
  sequence s_lc_end;
    (lc_q == lcfs_pkg::LC_SEND) ##1 (lc_q == lcfs_pkg::LC_IDLE);
  endsequence

  // Idle line at its limit with a free slot must open a link test
  property p_idle_gap;
    !rx_any && !is_lc && !fail_q && !bit_strobe_i && (gap_q >= IDLE_CYC) |=> is_lc;
  endproperty
  a_idle_gap: assert property (p_idle_gap) else $error("idle gap too long");
  property p_supp_gap;
    rx_any && !is_lc && !fail_q && !bit_strobe_i && (gap_q >= SUPP_CYC) |=> is_lc;
  endproperty
  a_supp_gap: assert property (p_supp_gap) else $error("link test held too long");
  // Reception must hold a test back past the suppression limit
  property p_no_early;
    s_lc_start |-> $past(gap_q) >= ($past(rx_any) ? SUPP_CYC : IDLE_CYC);
  endproperty
  a_no_early: assert property (p_no_early) else $error("link test too early");
  property p_four;
    s_lc_end |-> $past(sent_q) + 5'h01 >= lcfs_pkg::LC_MAND || fail_q;
  endproperty
  a_four: assert property (p_four) else $error("short link test");
  property p_opt;
    sent_q <= lcfs_pkg::LC_MAND + lcfs_pkg::LC_OPT_MAX;
  endproperty
  a_opt: assert property (p_opt) else $error("too many optional bits");
  property p_lc_flag;
    fv_q |-> fd_q[20] == $past(is_lc);
  endproperty
  a_lc_flag: assert property (p_lc_flag) else $error("link test flag wrong");
  property p_cnt;
    bit_strobe_i |=> bcnt_q == 3'($past(bcnt_q) + 3'h1);
  endproperty
  a_cnt: assert property (p_cnt) else $error("bit counter step");
  property p_fsk;
    fv_q && $past(fsk_rx_i) && !$past(is_lc) |-> fd_q[24:23] == 2'h0 && fd_q[21] && fd_q[19];
  endproperty
  a_fsk: assert property (p_fsk) else $error("FSK frame fields");
  property p_dec;
    fv_q |-> fd_q[24] == fd_q[23];
  endproperty
  a_dec: assert property (p_dec) else $error("decoding differs");
  property p_fail;
    fail_q |=> !fv_q && !line_active_o;
  endproperty
  a_fail: assert property (p_fail) else $error("activity after failure");
  property p_start;
    s_lc_start |-> !$past(bit_strobe_i);
  endproperty
  a_start: assert property (p_start) else $error("link test cut a frame");
endmodule : lcfs_top
`default_nettype wire

// ### bench/lcfs_rx_model.sv
// Receiver model of the output link: checks each CRC and supervises link tests
`timescale 1ns/10ps
`default_nettype none
module lcfs_rx_model #(
  parameter int WIN = 12000  // Supervision window in cycles
) (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        arst_n_i,
  // Frames from the link
  input  wire logic        frame_valid_i,
  input  wire logic [24:0] frame_data_i,
  // Verdicts
  output logic             crc_bad_o,
  output logic             link_fail_o
);
  int idle_q;  // Cycles since the last link test frame
  // CRC-8, polynomial 0x07, zero start, msb first
  function automatic logic [7:0] crc8(input logic [16:0] p);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 16; i >= 0; i--) r = {r[6:0], 1'b0} ^ ((r[7] ^ p[i]) ? 8'h07 : 8'h00);
    return r;
  endfunction : crc8
  // Verify each frame and age the last link test
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      crc_bad_o   <= 1'b0;
      link_fail_o <= 1'b0;
      idle_q      <= 0;
    end else begin
      if (frame_valid_i && crc8(frame_data_i[24:8]) !== frame_data_i[7:0]) crc_bad_o <= 1'b1;
      if (frame_valid_i && frame_data_i[20]) idle_q <= 0;
      else idle_q <= idle_q + 1;
      if (idle_q > WIN) link_fail_o <= 1'b1;
    end
  end
endmodule : lcfs_rx_model
`default_nettype wire

// ### bench/lcfs_top_tb_top.sv
// Self-checking testbench of the link check frame scheduler
`timescale 1ns/10ps
`default_nettype none
module lcfs_top_tb_top;
  typedef struct {longint t; logic [16:0] f;} lcfs_exp_t;  // Expected frame and launch time
  logic mclk_i = 1'b0, arst_n_i = 1'b0;  // Clock and reset
  logic [3:0] aw = 4'h0, ar = 4'h0, str = 4'h0;  // Addresses, strength
  logic [31:0] wd = 32'h0000_0000;  // Write data
  logic awv = 0, wv = 0, br = 0, arv = 0, rr = 0;  // Bus requests
  logic stb = 0, abit = 0, arx = 0, frx = 0, fl = 0;  // Air-gap side
  logic awr, wr, bv, arr, rv, fv, la, crc_bad, lfail;  // Design answers
  logic [1:0] bresp, rresp;
  logic [31:0] rd;
  logic [24:0] fd;
  lcfs_exp_t q[$];  // Notes of expected frames
  lcfs_exp_t e;
  logic [31:0] ctrl = lcfs_pkg::CTRL_RST;  // Control value in force
  logic fsk = 0, dead = 0, ok_start = 0;
  logic [2:0] cnt = 3'h0;  // Bench copy of the bit counter
  int err_total = 0, samples_checked = 0, seed = 32'hd44996ce;
  int opt = 0, lc_n = 0, lc_len = 0, lc_total = 0;
  longint lc_t = 0, lc_s = 0, lc_min = 0, lc_max = 0;
  // Shortened gaps; bit slots keep their length
  lcfs_top #(.IDLE_CYC(23'd2000), .SUPP_CYC(23'd7500)) u_lcfs_top (
    .mclk_i(mclk_i), .arst_n_i(arst_n_i), .s_awaddr_i(aw), .s_awvalid_i(awv),
    .s_awready_o(awr), .s_wdata_i(wd), .s_wstrb_i(4'hF), .s_wvalid_i(wv), .s_wready_o(wr),
    .s_bresp_o(bresp), .s_bvalid_o(bv), .s_bready_i(br), .s_araddr_i(ar), .s_arvalid_i(arv),
    .s_arready_o(arr), .s_rdata_o(rd), .s_rresp_o(rresp), .s_rvalid_o(rv), .s_rready_i(rr),
    .bit_strobe_i(stb), .ask_bit_i(abit), .ask_rx_i(arx), .fsk_rx_i(frx), .strength_i(str),
    .fail_i(fl), .frame_valid_o(fv), .frame_data_o(fd), .line_active_o(la));
  lcfs_rx_model u_lcfs_rx_model (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .frame_valid_i(fv),
    .frame_data_i(fd), .crc_bad_o(crc_bad), .link_fail_o(lfail));
  // Clock generator, 100 ns period
  initial forever #50 mclk_i = ~mclk_i;
  // Verdict and end of run
  task automatic test_done();
    if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  // Compare one value
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  // Bus write, both channels offered together
  task automatic wr32(input logic [3:0] a, input logic [31:0] d);
    aw <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    br <= 1'b1;
    do @(posedge mclk_i); while (!(awr && wr));
    awv <= 1'b0;
    wv <= 1'b0;
    do @(posedge mclk_i); while (!bv);
    br <= 1'b0;
    chk("bresp", 32'(lcfs_pkg::RESP_OK), 32'(bresp));
  endtask : wr32
  // Bus read with expected data and response
  task automatic rd32(input logic [3:0] a, input logic [31:0] x, input logic [1:0] re);
    ar <= a;
    arv <= 1'b1;
    rr <= 1'b1;
    do @(posedge mclk_i); while (!arr);
    arv <= 1'b0;
    do @(posedge mclk_i); while (!rv);
    rr <= 1'b0;
    chk("rdata", x, rd);
    chk("rresp", 32'(re), 32'(rresp));
  endtask : rd32
  // One air-gap bit with random value and level; note the frame it must give
  task automatic strobe();
    logic b;
    logic [3:0] s;
    b = 1'($random(seed));
    s = 4'($random(seed));
    stb <= 1'b1;
    abit <= b;
    str <= s;
    q.push_back('{$time, {fsk ? 2'b00 : {b, b}, ~ctrl[0], fsk, 1'b0, ctrl[0] | fsk,
                 ctrl[1] ? s : 4'h0, ctrl[9:8], ctrl[11:10], cnt}});
    cnt = cnt + 3'd1;
    @(posedge mclk_i);
    stb <= 1'b0;
  endtask : strobe
  // Reception mode with control value, spacing limits in ns, length in cycles
  task automatic phase(input logic [31:0] c, input logic a, input logic f,
                       input longint mn, input longint mx, input int n);
    int k;
    int g;
    wr32(lcfs_pkg::CTRL_OFS, c);
    ctrl = c;
    opt = c[7:4];
    fsk = f;
    arx <= a;
    frx <= f;
    lc_min = mn;
    lc_max = mx;
    ok_start = 0;
    k = 0;
    while (k < n) begin
      if (a | f) begin
        strobe();
        g = 1 + ($random(seed) & 31);
        repeat (g) @(posedge mclk_i);
        k += g + 1;
      end else begin
        @(posedge mclk_i);
        k++;
      end
    end
  endtask : phase
  // Monitor: link test frames checked in place, others against the oldest note
  always @(posedge mclk_i) begin
    if (fv === 1'b1 && dead) chk("frame after failure", 32'h0, 32'h1);
    else if (fv === 1'b1 && fd[20] === 1'b1) begin
      if ($time - lc_t > 15000) begin
        if (lc_n != 0) chk("link test length", 32'(lc_len), 32'(lc_n));
        if (ok_start) chk("link test spacing", 32'h1,
                          32'($time - lc_s > lc_min && $time - lc_s <= lc_max));
        lc_s = $time;
        ok_start = 1;
        lc_n = 0;
        lc_len = 4 + opt;
        lc_total++;
      end
      chk("link test bit", 32'(lc_n < 4 ? lcfs_pkg::LC_PATTERN[3 - lc_n] : 1'b0),
          32'(fd[24]));
      lc_n++;
      lc_t = $time;
    end else if (fv === 1'b1) begin
      // Strobes refused during a link test leave stale notes
      while (q.size() > 0 && q[0].t + 200 < $time) void'(q.pop_front());
      if (q.size() == 0) chk("frame unexpected", 32'h0, 32'h1);
      else begin
        e = q.pop_front();
        chk("frame", 32'(e.f), 32'(fd[24:8]));
      end
    end
  end
  // Watchdog against a hang
  initial begin
    #(100 * 90000);
    err_total++;
    test_done();
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    chk("line active", 32'h1, 32'(la));
    rd32(lcfs_pkg::CTRL_OFS, lcfs_pkg::CTRL_RST, lcfs_pkg::RESP_OK);
    wr32(lcfs_pkg::CTRL_OFS, 32'hFFFF_FFFF);
    rd32(lcfs_pkg::CTRL_OFS, lcfs_pkg::CTRL_WMASK, lcfs_pkg::RESP_OK);
    wr32(lcfs_pkg::FRAME_OFS, 32'h0000_1234);
    rd32(4'hC, 32'h0000_0000, lcfs_pkg::RESP_DEC);
    // Read-only frame register kept its reset value, status shows a live line
    rd32(lcfs_pkg::FRAME_OFS, 32'h0000_0000, lcfs_pkg::RESP_OK);
    rd32(lcfs_pkg::STAT_OFS, 32'h0000_0004, lcfs_pkg::RESP_OK);
    // Idle spacing allows for the unshortened link test length
    phase(32'h0000_0631, 0, 0, 0, 320000, 8000);
    chk("idle link tests", 32'h1, 32'(lc_total > 2));
    phase(32'h0000_0933, 1, 0, 500000, 1000000, 22000);
    phase(32'h0000_0CF3, 0, 1, 500000, 1000000, 22000);
    phase(32'h0000_0030, 1, 0, 0, 1000000, 2000);
    chk("crc", 32'h0, 32'(crc_bad));
    chk("link supervision", 32'h0, 32'(lfail));
    fl <= 1'b1;
    repeat (3) @(posedge mclk_i);
    chk("line after failure", 32'h0, 32'(la));
    dead = 1;
    repeat (10) begin
      strobe();
      @(posedge mclk_i);
    end
    repeat (12100) @(posedge mclk_i);
    chk("dead link seen", 32'h1, 32'(lfail));
    arst_n_i <= 1'b0;
    fl <= 1'b0;
    q.delete();
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    dead = 0;
    cnt = 3'h0;
    ctrl = lcfs_pkg::CTRL_RST;
    fsk = 0;
    repeat (2) @(posedge mclk_i);
    chk("line after reset", 32'h1, 32'(la));
    rd32(lcfs_pkg::CTRL_OFS, lcfs_pkg::CTRL_RST, lcfs_pkg::RESP_OK);
    strobe();
    repeat (5) @(posedge mclk_i);
    test_done();
  end
endmodule : lcfs_top_tb_top
`default_nettype wire
